// ---- rtl/ssync_pkg.sv ----
// shared constants for the clock-synchronous serial receive channel and its far-end transmitter
package ssync_pkg;
    // register byte offsets on the bus
    localparam logic [4:0] OFF_CTRL  = 5'h00;
    localparam logic [4:0] OFF_BRR   = 5'h04;
    localparam logic [4:0] OFF_STAT  = 5'h08;
    localparam logic [4:0] OFF_MASK  = 5'h0c;
    localparam logic [4:0] OFF_RDATA = 5'h10;
    // control field positions
    localparam int BIT_RX_EN  = 0;
    localparam int BIT_EXTCLK = 1;
    localparam int BIT_MSB    = 2;
    localparam int BIT_CKS_LO = 4;
    localparam int BIT_CKS_HI = 5;
    // status and mask field positions
    localparam int BIT_FULL = 0;
    localparam int BIT_OVR  = 1;
    // reset values
    localparam logic       RST_RX_EN  = 1'b0;
    localparam logic       RST_EXTCLK = 1'b0;
    localparam logic       RST_MSB    = 1'b0;
    localparam logic [1:0] RST_CKS    = 2'h0;
    localparam logic [7:0] RST_BRR    = 8'h00;
    localparam logic [1:0] RST_MASK   = 2'h0;
    // character format
    localparam int CHAR_BITS = 8;
    // timing
    localparam longint HCLK_HZ        = 25000000;
    localparam longint EXT_SCK_MAX_HZ = 8333333;
    // least half period of a supplied serial clock, in hclk cycles, rounded up
    localparam int EXT_HALF_MIN = int'((HCLK_HZ + 2 * EXT_SCK_MAX_HZ - 1) / (2 * EXT_SCK_MAX_HZ));
endpackage

// ---- rtl/ssync_link_if.sv ----
// serial link between the receive channel and the far-end transmitter
`timescale 1ns/1ps
`default_nettype none
interface ssync_link_if;
    logic dev_sck_o;
    logic dev_sck_oen;
    logic par_sck_o;
    logic par_sck_oen;
    logic sck;
    logic rxd;

    // the clock pin idles high through a pull-up; the device end wins a clash
    assign sck = !dev_sck_oen ? dev_sck_o : (!par_sck_oen ? par_sck_o : 1'b1);

    modport device (
        input  sck,
        input  rxd,
        output dev_sck_o,
        output dev_sck_oen
    );

    modport partner (
        input  sck,
        output rxd,
        output par_sck_o,
        output par_sck_oen
    );
endinterface
`default_nettype wire

// ---- rtl/serial_comm_channel.sv ----
// clock-synchronous serial receive channel with an ahb-lite register slave
//
// What this block does
// - samples data on serial clock; internal/external selectable
// - internal mode drives clock out on pin
// - external mode: far party supplies the clock
// - prescaler picks divide by 1, 4, 16, 64
// - internal mode times bits from baud generator
// - external mode uses only incoming clock
// - sender changes bit on falling edge only
// - receiver captures bit on rising edge
// - default order least significant bit first
// - line holds last bit after character
// - characters are always exactly eight bits
// - bit order selectable lsb or msb first
// - receive path double-buffered for back-to-back characters
// - receive-full interrupt when character becomes available
// - overrun detected, separate receive-error interrupt raised
// - internal rates 1 to 500 kbps supported
// - supplied clock must not exceed stated maximum
`timescale 1ns/1ps
`default_nettype none
module serial_comm_channel
    import ssync_pkg::*;
#(
    parameter int BRR_W = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq,
    output logic             receive_full_interrupt,
    output logic             receive_error_interrupt,
    ssync_link_if.device     link
);
    import ssync_pkg::*;

    localparam int CNT_W = BRR_W + 7;

    typedef struct packed {
        logic                 rx_en;
        logic                 ext_clk;
        logic                 msb_first;
        logic [1:0]           cks;
        logic [BRR_W-1:0]     brr;
        logic                 full;
        logic                 ovr;
        logic [1:0]           mask;
        logic [CHAR_BITS-1:0] rbuf;
        logic [CHAR_BITS-1:0] shift;
        logic [2:0]           bitcnt;
        logic [CNT_W-1:0]     cnt;
        logic                 sck;
        logic                 sck_prev;
        logic                 wr_pend;
        logic [4:0]           wr_addr;
        logic [31:0]          rdata;
    } rx_state_t;

    rx_state_t            s_reg;
    rx_state_t            s_next;
    logic                 rise;
    logic                 run;
    logic                 acc;
    logic [CNT_W-1:0]     lim;
    logic [CHAR_BITS-1:0] shifted;

    always_comb begin
        s_next = s_reg;
        // half period = (brr + 1) * 4^cks hclk cycles
        lim = (CNT_W'({1'b0, s_reg.brr}) + CNT_W'(1)) << {s_reg.cks, 1'b0};
        lim = lim - CNT_W'(1);
        // generator halts on overrun so the character in the buffer is not overtaken further
        run = s_reg.rx_en & ~s_reg.ext_clk & ~s_reg.ovr;
        rise = 1'b0;
        s_next.sck_prev = link.sck;

        if (!run) begin
            // idle level is high; a disable mid-character drops the partial character
            s_next.sck = 1'b1;
            s_next.cnt = '0;
        end else if (s_reg.cnt == lim) begin
            s_next.cnt = '0;
            s_next.sck = ~s_reg.sck;
            rise = ~s_reg.sck;
        end else begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
        end

        if (s_reg.ext_clk) begin
            // baud generator is parked; only the pin edge counts
            rise = s_reg.rx_en & link.sck & ~s_reg.sck_prev;
        end

        // shift direction follows the selected order
        if (s_reg.msb_first) begin
            shifted = {s_reg.shift[CHAR_BITS-2:0], link.rxd};
        end else begin
            shifted = {link.rxd, s_reg.shift[CHAR_BITS-1:1]};
        end

        // bus: write data phase
        if (s_reg.wr_pend) begin
            case (s_reg.wr_addr)
                OFF_CTRL: begin
                    s_next.rx_en     = hwdata[BIT_RX_EN];
                    s_next.ext_clk   = hwdata[BIT_EXTCLK];
                    s_next.msb_first = hwdata[BIT_MSB];
                    s_next.cks       = hwdata[BIT_CKS_HI:BIT_CKS_LO];
                end
                OFF_BRR: begin
                    s_next.brr = hwdata[BRR_W-1:0];
                end
                OFF_STAT: begin
                    if (hwdata[BIT_FULL]) begin
                        s_next.full = 1'b0;
                    end
                    if (hwdata[BIT_OVR]) begin
                        s_next.ovr = 1'b0;
                    end
                end
                OFF_MASK: begin
                    s_next.mask = hwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // bus: address phase
        acc = hsel & htrans[1] & hready;
        s_next.wr_pend = acc & hwrite;
        s_next.wr_addr = haddr[4:0];
        if (acc && !hwrite) begin
            case (haddr[4:0])
                OFF_CTRL:  s_next.rdata = {26'h0, s_reg.cks, 1'b0, s_reg.msb_first, s_reg.ext_clk, s_reg.rx_en};
                OFF_BRR:   s_next.rdata = {{(32-BRR_W){1'b0}}, s_reg.brr};
                OFF_STAT:  s_next.rdata = {30'h0, s_reg.ovr, s_reg.full};
                OFF_MASK:  s_next.rdata = {30'h0, s_reg.mask};
                OFF_RDATA: s_next.rdata = {24'h0, s_reg.rbuf};
                default:   s_next.rdata = 32'h0;
            endcase
            if (haddr[4:0] == OFF_RDATA) begin
                // taking the character frees the buffer
                s_next.full = 1'b0;
            end
        end

        // receive path; placed after the clears so a new event wins
        if (!s_reg.rx_en) begin
            s_next.bitcnt = 3'h0;
        end else if (rise) begin
            s_next.shift  = shifted;
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            if (s_reg.bitcnt == 3'(CHAR_BITS - 1)) begin
                if (s_reg.full) begin
                    // character lost; the buffered one is kept
                    s_next.ovr = 1'b1;
                end else begin
                    s_next.rbuf = shifted;
                    s_next.full = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg           <= '0;
            s_reg.rx_en     <= RST_RX_EN;
            s_reg.ext_clk   <= RST_EXTCLK;
            s_reg.msb_first <= RST_MSB;
            s_reg.cks       <= RST_CKS;
            s_reg.brr       <= BRR_W'(RST_BRR);
            s_reg.mask      <= RST_MASK;
            s_reg.sck       <= 1'b1;
            s_reg.sck_prev  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin is driven in internal mode, released in external mode
    assign link.dev_sck_o   = s_reg.sck;
    assign link.dev_sck_oen = s_reg.ext_clk;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_reg.rdata;

    assign receive_full_interrupt  = s_reg.full & s_reg.mask[BIT_FULL];
    assign receive_error_interrupt = s_reg.ovr & s_reg.mask[BIT_OVR];
    assign irq = receive_full_interrupt | receive_error_interrupt;

    // hsize is accepted but only whole-word transfers are meaningful
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:5]};
endmodule
`default_nettype wire

// ---- rtl/serial_channel_two.sv ----
// far-end clock-synchronous transmitter that feeds the receive channel
`timescale 1ns/1ps
`default_nettype none
module serial_channel_two
    import ssync_pkg::*;
#(
    parameter int HALF_CYC = EXT_HALF_MIN
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        drive_clk,
    input  wire logic        msb_first,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    ssync_link_if.partner    link
);
    import ssync_pkg::*;

    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_LOW  = 3'b010,
        P_HIGH = 3'b100
    } ph_t;

    typedef struct packed {
        ph_t                  ph;
        logic [15:0]          cnt;
        logic [CHAR_BITS-1:0] shift;
        logic [2:0]           bitcnt;
        logic                 loaded;
        logic                 busy;
        logic                 rxd;
        logic                 sck;
        logic                 sck_prev;
    } tx_state_t;

    tx_state_t s_reg;
    tx_state_t s_next;
    logic      fall;
    logic      take;

    localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

    always_comb begin
        s_next = s_reg;
        s_next.sck_prev = link.sck;
        fall = 1'b0;
        take = tx_valid & ~s_reg.loaded;
        if (take) begin
            s_next.shift  = tx_data;
            s_next.loaded = 1'b1;
        end
        if (!drive_clk) begin
            // follow the receiver's clock; char slots are counted from reset
            s_next.ph  = P_IDLE;
            s_next.sck = 1'b1;
            fall = ~link.sck & s_reg.sck_prev;
        end else begin
            case (s_reg.ph)
                P_IDLE: begin
                    s_next.sck = 1'b1;
                    if (s_reg.loaded) begin
                        s_next.ph  = P_LOW;
                        s_next.sck = 1'b0;
                        s_next.cnt = 16'h0;
                        fall = 1'b1;
                    end
                end
                P_LOW: begin
                    s_next.cnt = s_reg.cnt + 16'h1;
                    if (s_reg.cnt == HALF_LAST) begin
                        s_next.ph  = P_HIGH;
                        s_next.sck = 1'b1;
                        s_next.cnt = 16'h0;
                    end
                end
                P_HIGH: begin
                    s_next.cnt = s_reg.cnt + 16'h1;
                    if (s_reg.cnt == HALF_LAST) begin
                        s_next.cnt = 16'h0;
                        if (s_reg.bitcnt == 3'h0) begin
                            s_next.ph = P_IDLE;
                        end else begin
                            s_next.ph  = P_LOW;
                            s_next.sck = 1'b0;
                            fall = 1'b1;
                        end
                    end
                end
                default: begin
                    s_next.ph = P_IDLE;
                end
            endcase
        end
        // bits change only on a falling edge and hold until the next one
        // a character starts only at a slot boundary and owns the shifter until its eighth bit is out,
        // so a new load can neither corrupt it nor start in the middle of an empty slot
        if (fall && (s_reg.busy || (s_reg.loaded && s_reg.bitcnt == 3'h0))) begin
            s_next.rxd = msb_first ? s_reg.shift[CHAR_BITS-1] : s_reg.shift[0];
            s_next.shift = msb_first ? {s_reg.shift[CHAR_BITS-2:0], 1'b0} : {1'b0, s_reg.shift[CHAR_BITS-1:1]};
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            s_next.busy = 1'b1;
            if (s_reg.bitcnt == 3'(CHAR_BITS - 1)) begin
                s_next.busy   = 1'b0;
                s_next.loaded = 1'b0;
            end
        end else if (fall) begin
            // empty slot: line keeps the last bit, slot counting carries on
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg          <= '0;
            s_reg.ph       <= P_IDLE;
            s_reg.rxd      <= 1'b1;
            s_reg.sck      <= 1'b1;
            s_reg.sck_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tx_ready         = ~s_reg.loaded;
    assign link.rxd         = s_reg.rxd;
    // half period is HALF_CYC hclk cycles, by default the least allowed by the receiver
    assign link.par_sck_o   = s_reg.sck;
    assign link.par_sck_oen = ~drive_clk;
endmodule
`default_nettype wire

// ---- sim/ssync_link_properties.sv ----
// concurrent checks on the serial link that joins the receive channel and the far-end transmitter
`timescale 1ns/1ps
`default_nettype none
module ssync_link_properties (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oen,
    input wire logic par_sck_o,
    input wire logic par_sck_oen,
    input wire logic sck,
    input wire logic rxd
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    no_clk_clash_a: assert property (dev_sck_oen || par_sck_oen)
        else $error("both ends drive the clock pin");
    dev_clk_out_a: assert property (!dev_sck_oen |-> sck == dev_sck_o)
        else $error("clock pin does not follow the device drive");
    ext_clk_in_a: assert property (dev_sck_oen && !par_sck_oen |-> sck == par_sck_o)
        else $error("clock pin does not follow the supplied clock");
    pin_pullup_a: assert property (dev_sck_oen && par_sck_oen |-> sck)
        else $error("released clock pin not high");
    data_chg_low_a: assert property ($changed(rxd) |-> !sck)
        else $error("data moved while clock high");
    data_at_fall_a: assert property ($changed(rxd) && !par_sck_oen |-> $fell(sck))
        else $error("data moved away from a falling clock edge");
    data_hold_rise_a: assert property ($rose(sck) |-> $stable(rxd) [*2])
        else $error("data not steady around rising clock edge");
    ext_low_min_a: assert property ($fell(sck) && !par_sck_oen |-> !sck [*2])
        else $error("supplied clock low phase too short");
    ext_high_min_a: assert property ($rose(sck) && !par_sck_oen |-> sck [*2])
        else $error("supplied clock high phase too short");

    ext_clock_c: cover property ($fell(sck) && !par_sck_oen);
    int_clock_c: cover property ($fell(sck) && !dev_sck_oen);
    data_moves_c: cover property ($changed(rxd));
endmodule
`default_nettype wire

// ---- sim/tb_clock_sync_serial_receiver.sv ----
// self-checking bench: register bus, reception on supplied and internal clock, overrun
`timescale 1ns/1ps
`default_nettype none
module tb_clock_sync_serial_receiver;
    import ssync_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
    logic        rfi;
    logic        rei;
    logic        drive_clk;
    logic        msb_first;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [31:0] rd;
    int          n_fail;
    int          n_checks;

    ssync_link_if ssync_link_if_i ();
    serial_comm_channel serial_comm_channel_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq(irq), .receive_full_interrupt(rfi), .receive_error_interrupt(rei),
        .link(ssync_link_if_i.device));
    serial_channel_two serial_channel_two_i (
        .hclk(hclk), .hresetn(hresetn), .drive_clk(drive_clk), .msb_first(msb_first), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .link(ssync_link_if_i.partner));
    ssync_link_properties ssync_link_properties_i (
        .hclk(hclk), .hresetn(hresetn), .dev_sck_o(ssync_link_if_i.dev_sck_o),
        .dev_sck_oen(ssync_link_if_i.dev_sck_oen), .par_sck_o(ssync_link_if_i.par_sck_o),
        .par_sck_oen(ssync_link_if_i.par_sck_oen), .sck(ssync_link_if_i.sck), .rxd(ssync_link_if_i.rxd));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stuck();
        n_fail++;
        $display("[ERR] wait limit expected 1 seen 0");
        results();
    endtask

    // waits out the current phase; the slave may stretch either phase
    task automatic hold();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) stuck();
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {27'h0, a};
        hwrite <= w;
        hold();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        hold();
        rd = hrdata;
    endtask

    task automatic wrt(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask

    function automatic logic [31:0] ctrl(input logic ext, input logic msb, input logic [1:0] cks);
        ctrl = 32'h0;
        ctrl[BIT_RX_EN] = 1'b1;
        ctrl[BIT_EXTCLK] = ext;
        ctrl[BIT_MSB] = msb;
        ctrl[BIT_CKS_HI:BIT_CKS_LO] = cks;
    endfunction

    // tx_ready is looked at on the falling edge so the taking edge is known
    task automatic send(input logic [7:0] b);
        int k;
        @(posedge hclk);
        tx_data  <= b;
        tx_valid <= 1'b1;
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while (tx_ready !== 1'b1 && k < 500);
        if (k >= 500) stuck();
        @(posedge hclk);
        tx_valid <= 1'b0;
    endtask

    task automatic wait_irq(input logic e);
        int k;
        k = 0;
        do begin
            @(negedge hclk);
            k++;
        end while ((e ? rei : rfi) !== 1'b1 && k < 4000);
        if (k >= 4000) stuck();
    endtask

    task automatic lvl(input logic v, output int h);
        h = 0;
        while (ssync_link_if_i.sck === v && h < 300) begin
            @(negedge hclk);
            h++;
        end
        if (h >= 300) stuck();
    endtask

    task automatic t_regs();
        rdc("ctrl reset", OFF_CTRL, 32'h0);
        rdc("rate reset", OFF_BRR, 32'h0);
        rdc("status reset", OFF_STAT, 32'h0);
        rdc("mask reset", OFF_MASK, 32'h0);
        wrt(5'h14, 32'hffffffff);
        rdc("unmapped", 5'h14, 32'h0);
        wrt(OFF_MASK, 32'h3);
        rdc("mask", OFF_MASK, 32'h3);
        @(negedge hclk);
        chk("idle pins", {ssync_link_if_i.dev_sck_oen, ssync_link_if_i.sck, irq, hresp}, 32'h4);
        $display("test regs done");
    endtask

    task automatic rx_ext(input logic dm, input logic pm, input logic [7:0] d, input logic [7:0] e);
        wrt(OFF_CTRL, ctrl(1'b1, dm, 2'h0));
        msb_first <= pm;
        send(d);
        wait_irq(1'b0);
        rdc("status full", OFF_STAT, 32'h1);
        rdc("char", OFF_RDATA, {24'h0, e});
        rdc("status drained", OFF_STAT, 32'h0);
    endtask

    task automatic t_ext();
        wrt(OFF_CTRL, ctrl(1'b1, 1'b0, 2'h0));
        repeat (2) @(posedge hclk);
        drive_clk <= 1'b1;
        repeat (2) @(posedge hclk);
        rx_ext(1'b0, 1'b0, 8'ha5, 8'ha5);
        rx_ext(1'b1, 1'b1, 8'h3c, 8'h3c);
        rx_ext(1'b1, 1'b0, 8'h01, 8'h80);
        chk("device pin released", ssync_link_if_i.dev_sck_oen, 32'h1);
        $display("test external clock done");
    endtask

    // device still reads msb first while the sender goes lsb first, so bytes come back mirrored
    task automatic t_dbl();
        send(8'h96);
        wait_irq(1'b0);
        send(8'h69);
        rdc("first held", OFF_RDATA, 32'h69);
        wait_irq(1'b0);
        rdc("no overrun", OFF_STAT, 32'h1);
        $display("test back to back done");
    endtask

    task automatic t_ovr();
        send(8'h0f);
        wait_irq(1'b1);
        rdc("overrun", OFF_STAT, 32'h3);
        wrt(OFF_MASK, 32'h1);
        @(negedge hclk);
        chk("error masked", {irq, rfi, rei}, 32'h6);
        rdc("second kept", OFF_RDATA, 32'h96);
        wrt(OFF_STAT, 32'h3);
        @(negedge hclk);
        chk("cleared", {irq, rfi, rei}, 32'h0);
        $display("test overrun done");
    endtask

    // a fresh reset realigns the sender's eight-edge slots with the device bit counter
    task automatic t_int(input logic [1:0] c);
        int h;
        @(posedge hclk);
        drive_clk <= 1'b0;
        msb_first <= 1'b0;
        hresetn   <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        send(8'hc3 ^ {6'h0, c});
        wrt(OFF_MASK, 32'h1);
        wrt(OFF_BRR, 32'h1);
        wrt(OFF_CTRL, ctrl(1'b0, 1'b0, c));
        lvl(1'b1, h);
        lvl(1'b0, h);
        lvl(1'b1, h);
        chk("half high", h, 32'h2 << (2 * c));
        lvl(1'b0, h);
        chk("half low", h, 32'h2 << (2 * c));
        chk("pin driven", ssync_link_if_i.dev_sck_oen, 32'h0);
        wait_irq(1'b0);
        rdc("internal char", OFF_RDATA, {24'h0, 8'hc3 ^ {6'h0, c}});
        // the next slot is empty, so the line must still show the last bit sent, a one
        wait_irq(1'b0);
        rdc("line held", OFF_RDATA, 32'hff);
        $display("test internal clock done");
    endtask

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        hresetn   = 1'b0;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = 2'h0;
        hwrite    = 1'b0;
        hwdata    = 32'h0;
        drive_clk = 1'b0;
        msb_first = 1'b0;
        tx_data   = 8'h00;
        tx_valid  = 1'b0;
        n_fail    = 0;
        n_checks  = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_ext();
        t_dbl();
        t_ovr();
        for (int c = 0; c < 4; c++) t_int(c[1:0]);
        results();
    end
endmodule
`default_nettype wire
